// >>> src/adec_correct.sv
/*
 Gain and offset correction of a raw converter sample, combinational.
 Assumes raw and offset are two's complement and gain is unsigned 1.15.
*/
`timescale 1ns/10ps
`default_nettype none

module adec_correct
(
	// Sample and corrections
	input  wire logic [15:0] raw,
	input  wire logic [15:0] gain,
	input  wire logic [15:0] offset,
	// Corrected result
	output var  logic [15:0] result,
	output var  logic        sat
);

	function automatic logic [15:0] sat18(input logic [17:0] v);
		if ((&v[17:15]) | ~(|v[17:15]))
			return v[15:0];
		return v[17] ? 16'h8000 : 16'h7FFF;
	endfunction

	logic signed [32:0] prod;
	logic        [17:0] scaled;
	logic        [15:0] gcorr;
	logic        [17:0] sum;

	// Gain has one integer bit and fifteen fraction bits
	assign prod   = 33'($signed(raw)) * 33'($signed({1'b0, gain}));
	assign scaled = prod[32:15];
	// Outside signed 16-bit range after gain
	assign sat    = ~((&scaled[17:15]) | ~(|scaled[17:15]));
	assign gcorr  = sat18(scaled);
	// Offset applied after gain
	assign sum    = {{2{gcorr[15]}}, gcorr} + {{2{offset[15]}}, offset};
	assign result = sat18(sum);

endmodule

`default_nettype wire

// >>> src/adec_params.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 converter event and sequencing block.
 Assumes a byte-addressed bus with one 32-bit word per register.
*/
`ifndef ADEC_PARAMS_SVH
`define ADEC_PARAMS_SVH

`define ADEC_OFF_CFG       6'h00
`define ADEC_OFF_OFFSET    6'h04
`define ADEC_OFF_GAIN      6'h08
`define ADEC_OFF_DATA      6'h0C
`define ADEC_OFF_FLAGS     6'h10
`define ADEC_OFF_MASK      6'h14
`define ADEC_OFF_IRQSET    6'h18
`define ADEC_OFF_IRQCLR    6'h1C
`define ADEC_OFF_XFER      6'h20
`define ADEC_OFF_BEG       6'h24
`define ADEC_OFF_LEN       6'h28
`define ADEC_OFF_CUR       6'h2C
`define ADEC_OFF_STAT      6'h30

`define ADEC_FLG_DATA      0
`define ADEC_FLG_HALF      1
`define ADEC_FLG_FULL      2
`define ADEC_FLG_SAT       3
`define ADEC_FLG_OVF       4
`define ADEC_FLG_W         5

`define ADEC_XFER_LOAD     0
`define ADEC_XFER_WRAP     1
`define ADEC_XFER_RST      4
`define ADEC_IRQ_BIT       0
`define ADEC_CFG_W         13

`define ADEC_GAIN_RST      16'h8000
`define ADEC_OFFSET_RST    16'h0000
`define ADEC_BASE_CLKS     16'h0020

`define ADEC_STARTUP_US    21
`define ADEC_CLK_PERIOD_PS 4000

`endif

// >>> src/adec_pkg.sv
/*
 Types of the converter event and sequencing block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adec_pkg;

	typedef enum logic [1:0] {adec_off, adec_warm, adec_conv} adec_state_e;

	typedef struct packed {
		logic [3:0] mux_p;
		logic [3:0] mux_n;
		logic [2:0] period;
		logic       clk_1mhz;
		logic       en;
	} adec_cfg_s;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [15:0] data;
	} adec_mem_s;

endpackage

// >>> src/adec_top.sv
/*
 Converter control: Avalon-MM register slave, event flags with mask and
 interrupt, enable and conversion sequencing, correction and sample DMA.
 Assumes sampling ticks and raw samples synchronous to clock, and a RAM
 that accepts one half-word write per cycle without back-pressure.
*/
// Our own choices: the Avalon-MM register port and the register offsets.
`include "adec_params.svh"
`timescale 1ns/10ps
`default_nettype none

module adec_top
#(
	parameter int STARTUP_CYCLES =
		(`ADEC_STARTUP_US * 1000 * 1000 + `ADEC_CLK_PERIOD_PS - 1) / `ADEC_CLK_PERIOD_PS
)
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               srst,
	// Avalon-MM slave
	input  wire logic [5:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output var  logic [31:0]        avs_readdata,
	output var  logic               avs_waitrequest,
	// Analog core
	input  wire logic               tick_1mhz,
	input  wire logic               tick_6mhz,
	input  wire logic [15:0]        adc_raw,
	input  wire logic               clk_switch,
	output var  adec_pkg::adec_cfg_s ana_cfg,
	// Sample DMA to RAM
	output var  adec_pkg::adec_mem_s mem_wr,
	// Interrupt request
	output var  logic               irq
);

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			m[8*i +: 8] = {8{be[i]}};
		return m;
	endfunction

	function automatic logic [15:0] half_addr(input logic [15:0] beg, input logic [15:0] idx);
		// Target kept on a half-word boundary
		return {beg[15:1], 1'b0} + {idx[14:0], 1'b0};
	endfunction

	adec_pkg::adec_cfg_s   cfg_r;
	adec_pkg::adec_state_e state_r;
	adec_pkg::adec_state_e state_nxt;
	adec_pkg::adec_mem_s   mem_r;
	logic [15:0]           offset_r;
	logic [15:0]           gain_r;
	logic [15:0]           data_r;
	logic [`ADEC_FLG_W-1:0] flags_r;
	logic [`ADEC_FLG_W-1:0] mask_r;
	logic                  irq_en_r;
	logic                  irq_r;
	logic                  run_r;
	logic                  wrap_r;
	logic [15:0]           beg_r;
	logic [15:0]           len_r;
	logic [15:0]           idx_r;
	logic [15:0]           cnt_r;
	logic [15:0]           cnt_nxt;
	logic                  discard_r;
	logic                  discard_nxt;
	logic                  restart_r;
	logic                  wait_r;
	logic [31:0]           rdata_r;

	// Bus handshake: one wait state; writes act when waitrequest is low, reads are sampled in the wait cycle
	wire logic        req      = avs_read | avs_write;
	wire logic        wr_ok    = avs_write & ~wait_r;
	wire logic        rd_take  = avs_read & wait_r;
	wire logic [31:0] wbits    = avs_writedata & lane_mask(avs_byteenable);
	wire logic [31:0] lmask    = lane_mask(avs_byteenable);

	wire logic hit_cfg    = avs_address == `ADEC_OFF_CFG;
	wire logic hit_offset = avs_address == `ADEC_OFF_OFFSET;
	wire logic hit_gain   = avs_address == `ADEC_OFF_GAIN;
	wire logic hit_data   = avs_address == `ADEC_OFF_DATA;
	wire logic hit_flags  = avs_address == `ADEC_OFF_FLAGS;
	wire logic hit_mask   = avs_address == `ADEC_OFF_MASK;
	wire logic hit_irqset = avs_address == `ADEC_OFF_IRQSET;
	wire logic hit_irqclr = avs_address == `ADEC_OFF_IRQCLR;
	wire logic hit_xfer   = avs_address == `ADEC_OFF_XFER;
	wire logic hit_beg    = avs_address == `ADEC_OFF_BEG;
	wire logic hit_len    = avs_address == `ADEC_OFF_LEN;
	wire logic hit_cur    = avs_address == `ADEC_OFF_CUR;
	wire logic hit_stat   = avs_address == `ADEC_OFF_STAT;

	wire logic [15:0] cur_addr = half_addr(beg_r, idx_r);
	wire logic [31:0] cfg_word = {19'h0, cfg_r};
	wire logic [31:0] cfg_new  = (cfg_word & ~lmask) | wbits;
	wire logic [31:0] off_new  = ({16'h0, offset_r} & ~lmask) | wbits;
	wire logic [31:0] gain_new = ({16'h0, gain_r} & ~lmask) | wbits;
	wire logic [31:0] beg_new  = ({16'h0, beg_r} & ~lmask) | wbits;
	wire logic [31:0] len_new  = ({16'h0, len_r} & ~lmask) | wbits;

	// Read selection; unmapped offsets read zero
	wire logic [31:0] rd_word =
		hit_cfg    ? cfg_word :
		hit_offset ? {16'h0, offset_r} :
		hit_gain   ? {16'h0, gain_r} :
		hit_data   ? {16'h0, data_r} :
		hit_flags  ? {27'h0, flags_r} :
		hit_mask   ? {27'h0, mask_r} :
		(hit_irqset | hit_irqclr) ? {31'h0, irq_en_r} :
		hit_xfer   ? {30'h0, wrap_r, run_r} :
		hit_beg    ? {16'h0, beg_r} :
		hit_len    ? {16'h0, len_r} :
		hit_cur    ? {16'h0, cur_addr} :
		hit_stat   ? {29'h0, discard_r, state_r == adec_pkg::adec_warm,
		              state_r == adec_pkg::adec_conv} :
		32'h0000_0000;

	// Sequencer terms
	wire logic        cfg_wr    = wr_ok & hit_cfg;
	wire logic        tick      = cfg_r.clk_1mhz ? tick_1mhz : tick_6mhz;
	// Conversion length doubles per code step
	wire logic [15:0] conv_len  = `ADEC_BASE_CLKS << cfg_r.period;
	wire logic        conv_end  = (state_r == adec_pkg::adec_conv) & cfg_r.en & ~restart_r &
	                              tick & (cnt_r == conv_len - 16'h0001);
	wire logic        res_fire  = conv_end & ~discard_r;

	// Correction of the raw sample
	logic [15:0] corr_result;
	logic        corr_sat;

	adec_correct u_correct
	(
		.raw    (adc_raw),
		.gain   (gain_r),
		.offset (offset_r),
		.result (corr_result),
		.sat    (corr_sat)
	);

	// DMA terms
	wire logic xfer_wr   = wr_ok & hit_xfer;
	wire logic xfer_rst  = xfer_wr & wbits[`ADEC_XFER_RST];
	wire logic xfer_load = xfer_wr & wbits[`ADEC_XFER_LOAD];
	wire logic store     = res_fire & run_r;
	wire logic last_slot = idx_r == len_r - 16'h0001;
	wire logic half_slot = idx_r == ((len_r + 16'h0001) >> 1) - 16'h0001;

	// Event set and clear vectors
	wire logic [`ADEC_FLG_W-1:0] flag_set =
	{
		res_fire & ~run_r,
		res_fire & corr_sat,
		store & last_slot,
		store & half_slot,
		res_fire
	};
	// Only ones written clear
	wire logic [`ADEC_FLG_W-1:0] flag_clr =
		(wr_ok & hit_flags) ? wbits[`ADEC_FLG_W-1:0] : 5'h00;
	// Set beats a clear in the same cycle
	wire logic [`ADEC_FLG_W-1:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;

	// Sequencing of startup, discard and continuous conversion
	always_comb
	begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		discard_nxt = discard_r;
		unique case (state_r)
			adec_pkg::adec_off:
			begin
				cnt_nxt = 16'h0000;
				if (cfg_r.en)
				begin
					// Startup wait then a discarded conversion
					state_nxt   = adec_pkg::adec_warm;
					discard_nxt = 1'b1;
				end
			end
			adec_pkg::adec_warm:
			begin
				if (!cfg_r.en)
					state_nxt = adec_pkg::adec_off;
				else if (cnt_r == 16'(STARTUP_CYCLES - 1))
				begin
					state_nxt = adec_pkg::adec_conv;
					cnt_nxt   = 16'h0000;
				end
				else
					cnt_nxt = cnt_r + 16'h0001;
			end
			adec_pkg::adec_conv:
			begin
				if (!cfg_r.en)
					state_nxt = adec_pkg::adec_off;
				else if (restart_r)
				begin
					// Config write or clock switch restarts with a discard
					cnt_nxt     = 16'h0000;
					discard_nxt = 1'b1;
				end
				else if (conv_end)
				begin
					// Back-to-back conversions while enabled
					cnt_nxt     = 16'h0000;
					discard_nxt = 1'b0;
				end
				else if (tick)
					cnt_nxt = cnt_r + 16'h0001;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_r   <= adec_pkg::adec_off;
			cnt_r     <= 16'h0000;
			discard_r <= 1'b0;
			restart_r <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			discard_r <= discard_nxt;
			restart_r <= cfg_wr | clk_switch;
		end
	end

	// Bus slave
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			wait_r <= ~(req & wait_r);
			if (rd_take)
				rdata_r <= rd_word;
		end
	end

	// Software registers
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			cfg_r    <= '0;
			offset_r <= `ADEC_OFFSET_RST;
			gain_r   <= `ADEC_GAIN_RST;
			mask_r   <= 5'h00;
			irq_en_r <= 1'b0;
			beg_r    <= 16'h0000;
			len_r    <= 16'h0000;
		end
		else
		begin
			if (cfg_wr)
				cfg_r <= cfg_new[`ADEC_CFG_W-1:0];
			if (wr_ok & hit_offset)
				offset_r <= off_new[15:0];
			if (wr_ok & hit_gain)
				gain_r <= gain_new[15:0];
			if (wr_ok & hit_mask)
				mask_r <= (mask_r & ~lmask[4:0]) | wbits[4:0];
			// Interrupt enable set and clear
			if (wr_ok & hit_irqset & wbits[`ADEC_IRQ_BIT])
				irq_en_r <= 1'b1;
			else if (wr_ok & hit_irqclr & wbits[`ADEC_IRQ_BIT])
				irq_en_r <= 1'b0;
			if (wr_ok & hit_beg)
				beg_r <= beg_new[15:0];
			if (wr_ok & hit_len)
				len_r <= len_new[15:0];
		end
	end

	// Result, flags and interrupt
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			data_r  <= 16'h0000;
			flags_r <= 5'h00;
			irq_r   <= 1'b0;
		end
		else
		begin
			if (res_fire)
				data_r <= corr_result;
			flags_r <= flags_nxt;
			// Masked flags merge into one request
			irq_r   <= irq_en_r & (|(flags_r & mask_r));
		end
	end

	// Sample DMA; config writes leave it running
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			run_r  <= 1'b0;
			wrap_r <= 1'b0;
			idx_r  <= 16'h0000;
			mem_r  <= '0;
		end
		else
		begin
			mem_r.we <= store;
			if (store)
			begin
				mem_r.addr <= cur_addr;
				mem_r.data <= corr_result;
			end
			if (xfer_rst)
			begin
				run_r <= 1'b0;
				idx_r <= 16'h0000;
			end
			else if (xfer_wr)
			begin
				wrap_r <= wbits[`ADEC_XFER_WRAP];
				if (xfer_load)
					run_r <= 1'b1;
			end
			else if (store)
			begin
				if (last_slot)
				begin
					// Wrap returns to start; linear stops when full
					idx_r <= 16'h0000;
					run_r <= wrap_r;
				end
				else
					idx_r <= idx_r + 16'h0001;
			end
		end
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign ana_cfg         = cfg_r;
	assign mem_wr          = mem_r;
	assign irq             = irq_r;

endmodule

`default_nettype wire

// >>> testbench/adec_checker_sva.sv
/*
 Concurrent checks on the ports of adec_top.
 Assumes a bind from the bench top and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module adec_checker
#(
	parameter int STARTUP_CYCLES = 8
)
(
	// Clock and reset
	input wire logic                clock,
	input wire logic                srst,
	// Register bus
	input wire logic [5:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [31:0]         avs_writedata,
	input wire logic [3:0]          avs_byteenable,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest,
	// Converter, store and interrupt
	input wire adec_pkg::adec_cfg_s ana_cfg,
	input wire adec_pkg::adec_mem_s mem_wr,
	input wire logic                irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	logic        wr_done;
	logic [4:0]  mask_r;
	logic        irq_en_r;
	logic [15:0] on_cnt_r;

	assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

	// Shadow of mask and interrupt enable, rebuilt from bus writes
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mask_r <= 5'h00;
			irq_en_r <= 1'b0;
		end
		else
		begin
			if (wr_done && avs_address == 6'h14)
				mask_r <= avs_writedata[4:0];
			if (wr_done && avs_address == 6'h18 && avs_writedata[0])
				irq_en_r <= 1'b1;
			else if (wr_done && avs_address == 6'h1C && avs_writedata[0])
				irq_en_r <= 1'b0;
		end
	end

	// Cycles since the converter was switched on
	always_ff @(posedge clock)
	begin
		if (srst || !ana_cfg.en)
			on_cnt_r <= 16'h0000;
		else if (on_cnt_r != 16'hFFFF)
			on_cnt_r <= on_cnt_r + 16'h0001;
	end

	AST_WAIT_ANSWER:
	assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	AST_WAIT_ONE:
	assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_READ_UPPER:
	assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	AST_CFG_MIRROR:
	assert property (wr_done && avs_byteenable == 4'hF && avs_address == 6'h00
		|=> ana_cfg == $past(avs_writedata[12:0]))
		else $error("configuration output does not follow write");
	AST_IRQ_MASKED:
	assert property (mask_r == 5'h00 || !irq_en_r |=> !irq)
		else $error("interrupt raised while masked or disabled");
	AST_STORE_EVEN:
	assert property (mem_wr.we |-> mem_wr.addr[0] == 1'b0)
		else $error("store to odd address");
	AST_STORE_PULSE:
	assert property (mem_wr.we |=> !mem_wr.we)
		else $error("store strobe longer than one cycle");
	AST_FIRST_RESULT:
	assert property (mem_wr.we |-> on_cnt_r >= STARTUP_CYCLES + 64)
		else $error("store too soon after enable");
endmodule

`default_nettype wire

// >>> testbench/adec_ram_model.sv
/*
 Half-word RAM written by the sample store port.
 Assumes byte addresses below 0x200 and one store per cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module adec_ram_model
(
	// Clock
	input wire logic                clock,
	// Store port
	input wire adec_pkg::adec_mem_s mem_wr,
	// Store to an odd address seen
	output var logic                odd_seen
);
	logic [15:0] mem [0:255];

	initial odd_seen = 1'b0;

	always @(posedge clock)
	begin
		if (mem_wr.we)
		begin
			mem[mem_wr.addr[8:1]] <= mem_wr.data;
			if (mem_wr.addr[0])
				odd_seen <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
/*
 Self-checking bench of adec_top over its Avalon-MM port.
 Assumes a short startup parameter and a 6 MHz tick every second cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	localparam int SU = 8;

	logic                clock;
	logic                srst;
	logic [5:0]          avs_address;
	logic                avs_read;
	logic                avs_write;
	logic [31:0]         avs_writedata;
	logic [3:0]          avs_byteenable;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic                tick_1mhz;
	logic                tick_6mhz;
	logic [15:0]         adc_raw;
	logic                clk_switch;
	adec_pkg::adec_cfg_s ana_cfg;
	adec_pkg::adec_mem_s mem_wr;
	logic                irq;
	logic                odd_seen;
	int                  miscompares;
	int                  checks;
	int                  cyc;
	int                  t0;
	logic [31:0]         q;

	adec_top #(.STARTUP_CYCLES(SU)) dut (.clock(clock), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.tick_1mhz(tick_1mhz), .tick_6mhz(tick_6mhz), .adc_raw(adc_raw),
		.clk_switch(clk_switch), .ana_cfg(ana_cfg), .mem_wr(mem_wr), .irq(irq));

	adec_ram_model ram (.clock(clock), .mem_wr(mem_wr), .odd_seen(odd_seen));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		tick_6mhz <= ~tick_6mhz;
	end

	task automatic end_of_test();
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
		int n;
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
		if (n >= 100)
		begin
			miscompares++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b1, a, 32'h0);
		chk(q & m, e);
	endtask

	task automatic wri(input logic [5:0] a, input logic [31:0] d, input logic e);
		wr(a, d);
		@(posedge clock);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task automatic wait_flag(input int b);
		int n;
		n = 0;
		q = 32'h0;
		while (q[b] !== 1'b1 && n < 600)
		begin
			bus(1'b1, 6'h10, 32'h0);
			n++;
		end
		if (n >= 600)
		begin
			miscompares++;
			end_of_test();
		end
	endtask

	initial
	begin
		srst = 1'b1;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{tick_1mhz, tick_6mhz, clk_switch, miscompares, checks, cyc} = '0;
		adc_raw = 16'h0100;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rdc(6'h08, 32'hFFFF, 32'h8000);
		rdc(6'h04, 32'hFFFF, 32'h0000);
		rdc(6'h3C, 32'hFFFFFFFF, 32'h0);
		// Polled conversion with half gain and an offset
		wr(6'h14, 32'h0);
		wr(6'h08, 32'h4000);
		wr(6'h04, 32'h0010);
		wr(6'h00, 32'h1);
		t0 = cyc;
		wr(6'h10, 32'h1F);
		wait_flag(0);
		chk(cyc - t0 >= 130 && cyc - t0 <= 150, 1);
		rdc(6'h0C, 32'hFFFF, 32'h0090);
		rdc(6'h10, 32'h10, 32'h10);
		wr(6'h08, 32'hFFFF);
		adc_raw <= 16'h7000;
		wr(6'h10, 32'h1F);
		wait_flag(0);
		wr(6'h00, 32'h0);
		rdc(6'h10, 32'h1F, 32'h19);
		wr(6'h10, 32'h0);
		rdc(6'h10, 32'h1F, 32'h19);
		wr(6'h10, 32'h08);
		rdc(6'h10, 32'h1F, 32'h11);
		// Interrupt gating
		wri(6'h18, 32'h1, 1'b0);
		wri(6'h14, 32'h08, 1'b0);
		wri(6'h14, 32'h10, 1'b1);
		wri(6'h1C, 32'h1, 1'b0);
		wri(6'h18, 32'h1, 1'b1);
		wri(6'h14, 32'h0, 1'b0);
		// Linear transfer of four samples
		wr(6'h08, 32'h8000);
		wr(6'h04, 32'h0);
		adc_raw <= 16'h0042;
		wr(6'h20, 32'h10);
		wr(6'h24, 32'h100);
		wr(6'h28, 32'h4);
		wr(6'h20, 32'h01);
		wr(6'h00, 32'h1);
		wr(6'h10, 32'h1F);
		wait_flag(2);
		rdc(6'h10, 32'h16, 32'h06);
		rdc(6'h20, 32'h1, 32'h0);
		for (int i = 0; i < 4; i++)
			chk({16'h0, ram.mem[8'h80 + i]}, 32'h0042);
		wait_flag(4);
		// Wraparound transfer across a configuration write
		wr(6'h20, 32'h10);
		wr(6'h20, 32'h03);
		wr(6'h10, 32'h1F);
		wait_flag(2);
		wr(6'h00, 32'h1);
		rdc(6'h20, 32'h3, 32'h3);
		wr(6'h10, 32'h14);
		wait_flag(2);
		rdc(6'h30, 32'h4, 32'h0);
		clk_switch <= 1'b1;
		@(posedge clock);
		clk_switch <= 1'b0;
		repeat (2) @(posedge clock);
		rdc(6'h30, 32'h4, 32'h4);
		rdc(6'h10, 32'h10, 32'h0);
		chk({31'h0, odd_seen}, 32'h0);
		end_of_test();
	end
endmodule

bind adec_top adec_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.clock(clock),
	.srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.ana_cfg(ana_cfg), .mem_wr(mem_wr), .irq(irq));

`default_nettype wire
